/* File: src/eptf_dev.sv */
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - iv leads payload when cipher needs it
// - iv bytes are not encrypted
// - no iv without confidentiality
// - tfc bytes between payload and padding
// - host enables tfc only when negotiated
// - pad to cipher block multiple
// - pad so icv is 4-byte aligned
// - incrementing pad generated, stripped on receive
// - received padding checked against pattern
// - 8-bit pad length, zero means none
// - 8-bit next header after pad length
// - icv only with integrity, configured size
// - encrypt computes and appends icv
// - decrypt recomputes and compares icv
// - inbound only after sa and replay checks
// - host loads context before each packet
// - host buffers input and output data
// - esn high bits in icv, not sent
// - spi is opaque 32-bit selector
module eptf_dev (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  // link to host wrapper
  eptf_if.dev             esp,
  // per-packet receive status
  output logic [7:0]      o_next_hdr,
  output logic            o_icv_fail,
  output logic            o_pad_fail
);
  import eptf_pkg::*;

  typedef struct packed {
    eptf_st_t   st;
    eptf_ctx_t  ctx;
    logic [10:0] idx;
    logic [10:0] s_end;
    logic [7:0]  len8;
    logic [7:0]  pad;
    logic [7:0]  pc;
    logic [31:0] sum;
    logic        ir;
    logic        ov;
    logic [7:0]  od;
    logic        ol;
    logic        oc;
    logic        eicv;
    logic        epad;
    logic        busy;
    logic [7:0]  nh;
  } eptf_dev_t;

  eptf_dev_t    r;
  eptf_dev_t    n;
  logic [7:0]   mem [MEM_DEPTH];
  logic         free;
  logic         emit;
  logic         mixit;
  logic         to_pad;
  logic [7:0]   b_v;
  logic         c_v;
  logic         l_v;
  logic [10:0]  ic;
  logic [10:0]  ivn;
  logic [10:0]  start;
  logic [10:0]  tail;
  logic [7:0]   mask;
  logic [31:0]  fin;
  logic [31:0]  icv_sh;
  logic [1:0]   icv_k;
  logic [63:0]  hdr_sh;
  logic [127:0] iv_sh;
  logic [7:0]   rd;
  logic [7:0]   rd_nh;
  logic [7:0]   padv;
  logic         mem_we;

  // running check sum; stands in for the hash core
  function automatic logic [31:0] mix(input logic [31:0] s, input logic [7:0] b);
    mix = {s[30:0], s[31]} ^ {24'h000000, b};
  endfunction

  // fold the unsent high sequence word into the sum
  function automatic logic [31:0] fold(input logic [31:0] s, input logic [31:0] w);
    logic [31:0] t;
    t = s;
    for (int k = 0; k < 4; k++) begin
      t = mix(t, w[8*(3-k) +: 8]);
    end
    fold = t;
  endfunction

  // padding count for the body length so far
  function automatic logic [7:0] pad_of(input logic [7:0] l, input logic [7:0] m);
    logic [7:0] t;
    t = l + 8'h02;
    pad_of = (8'h00 - t) & m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // derived context values
  assign ic     = r.ctx.integ_en ? {6'h00, r.ctx.icv_len} : 11'h000;
  assign ivn    = r.ctx.conf_en ? {6'h00, r.ctx.iv_len} : 11'h000;
  assign start  = HDR_LEN + ivn;
  assign tail   = r.ctx.pkt_len - ic;
  assign mask   = r.ctx.conf_en ? r.ctx.blk_mask : ALIGN4;
  assign fin    = r.ctx.esn_en ? fold(r.sum, r.ctx.seq_hi) : r.sum;
  assign icv_k  = (r.st == S_DIN) ? (r.idx[1:0] - tail[1:0]) : r.idx[1:0];
  assign icv_sh = fin >> {icv_k, 3'b000};
  assign hdr_sh = {r.ctx.spi, r.ctx.seq_lo} << {r.idx[2:0], 3'b000};
  assign iv_sh  = r.ctx.iv << {r.idx[3:0], 3'b000};
  assign rd     = mem[r.idx];
  assign rd_nh  = mem[r.idx + 11'h001];
  assign free   = !r.ov || esp.out_ready;
  assign mem_we = (r.st == S_DIN) && r.ir && esp.in_valid;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n      = r;
    emit   = 1'b0;
    mixit  = 1'b1;
    to_pad = 1'b0;
    b_v    = 8'h00;
    c_v    = r.ctx.conf_en;
    l_v    = 1'b0;
    padv   = 8'h00;
    if (r.ov && esp.out_ready) begin
      n.ov = 1'b0;
    end
    case (r.st)
      S_IDLE: if (esp.ctx_load) begin
        n.ctx  = esp.ctx;
        n.idx  = 11'h000;
        n.len8 = 8'h00;
        n.sum  = ICV_SEED;
        n.eicv = 1'b0;
        n.epad = 1'b0;
        n.st   = esp.ctx.decrypt ? S_DIN : S_HDR;
      end
      S_HDR: if (free) begin
        emit  = 1'b1;
        b_v   = hdr_sh[63:56];                                // low word only
        c_v   = 1'b0;
        n.idx = r.idx + 11'h001;
        if (r.idx == HDR_LEN - 11'h001) begin
          n.idx = 11'h000;
          n.st  = (ivn != 11'h000) ? S_IV : S_BODY;
        end
      end
      S_IV: if (free) begin
        emit  = 1'b1;
        b_v   = iv_sh[127:120];
        c_v   = 1'b0;
        n.idx = r.idx + 11'h001;
        if (r.idx == ivn - 11'h001) begin
          n.st = S_BODY;
        end
      end
      S_BODY: if (r.ir && esp.in_valid) begin
        emit   = 1'b1;
        b_v    = esp.in_data;
        n.len8 = r.len8 + 8'h01;
        if (esp.in_last) begin
          n.idx = 11'h000;
          if (r.ctx.tfc_en && r.ctx.tfc_len != 8'h00) begin
            n.st = S_TFC;
          end else begin
            to_pad = 1'b1;
          end
        end
      end
      S_TFC: if (free) begin
        emit   = 1'b1;                                        // zero filler
        n.len8 = r.len8 + 8'h01;
        n.idx  = r.idx + 11'h001;
        to_pad = (r.idx[7:0] == r.ctx.tfc_len - 8'h01);
      end
      S_PAD: if (free) begin
        emit = 1'b1;
        b_v  = r.pc;
        n.pc = r.pc + 8'h01;
        if (r.pc == r.pad) begin
          n.st = S_PLEN;
        end
      end
      S_PLEN: if (free) begin
        emit = 1'b1;
        b_v  = r.pad;
        n.st = S_NHDR;
      end
      S_NHDR: if (free) begin
        emit  = 1'b1;
        b_v   = r.ctx.next_hdr;
        l_v   = (ic == 11'h000);
        n.idx = 11'h000;
        n.st  = (ic == 11'h000) ? S_IDLE : S_ICV;
      end
      S_ICV: if (free) begin
        emit  = 1'b1;
        mixit = 1'b0;
        b_v   = icv_sh[7:0];
        c_v   = 1'b0;
        l_v   = (r.idx == ic - 11'h001);
        n.idx = r.idx + 11'h001;
        if (l_v) begin
          n.st = S_IDLE;
        end
      end
      S_DIN: if (r.ir && esp.in_valid) begin
        if (r.idx < tail) begin
          n.sum = mix(r.sum, esp.in_data);
        end else if (esp.in_data != icv_sh[7:0]) begin
          n.eicv = 1'b1;
        end
        n.idx = r.idx + 11'h001;
        if (r.idx == r.ctx.pkt_len - 11'h001) begin
          n.idx = tail - 11'h002;
          n.st  = S_DLEN;
        end
      end
      S_DLEN: begin
        n.pad   = rd;
        n.nh    = rd_nh;
        n.pc    = 8'h01;
        n.s_end = r.idx - {3'h0, rd};
        n.idx   = r.idx - {3'h0, rd};
        n.st    = (rd == 8'h00) ? S_DOUT : S_DCHK;
        if ({3'h0, rd} > r.idx - start) begin
          n.epad  = 1'b1;                                     // pad longer than body
          n.s_end = start;
          n.st    = S_DOUT;
        end
        if (n.st == S_DOUT) begin
          n.idx = start;                                      // iv dropped
        end
      end
      S_DCHK: begin
        if (rd != r.pc) begin
          n.epad = 1'b1;
        end
        n.pc  = r.pc + 8'h01;
        n.idx = r.idx + 11'h001;
        if (r.pc == r.pad) begin
          n.idx = start;
          n.st  = S_DOUT;
        end
      end
      S_DOUT: if (free) begin
        emit  = 1'b1;
        mixit = 1'b0;
        b_v   = (r.idx < r.s_end) ? rd : 8'h00;               // pad stripped
        l_v   = (r.idx + 11'h001 >= r.s_end);
        n.idx = r.idx + 11'h001;
        if (l_v) begin
          n.st = S_IDLE;
        end
      end
      default: n.st = S_IDLE;
    endcase
    // common output slot load
    if (emit) begin
      n.ov = 1'b1;
      n.od = b_v;
      n.oc = c_v;
      n.ol = l_v;
      if (mixit) begin
        n.sum = mix(r.sum, b_v);
      end
    end
    // pad sized once body and tfc lengths are known
    if (to_pad) begin
      padv  = pad_of(n.len8, mask);                           // length incl. this byte
      n.pad = padv;
      n.pc  = 8'h01;
      n.st  = (padv != 8'h00) ? S_PAD : S_PLEN;
    end
    // body bytes accepted only into an empty slot (decrypt input always); halves rate but needs no skid buffer
    n.ir   = ((n.st == S_BODY) && !n.ov) || (n.st == S_DIN);
    n.busy = (n.st != S_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      r    <= '0;
      r.st <= S_IDLE;
    end else begin
      r <= n;
    end
  end

  // received packet store; no reset needed, read only after written
  always_ff @(posedge i_clock) begin
    if (mem_we) begin
      mem[r.idx] <= esp.in_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign esp.busy        = r.busy;
  assign esp.in_ready    = r.ir;
  assign esp.out_valid   = r.ov;
  assign esp.out_data    = r.od;
  assign esp.out_last    = r.ol;
  assign esp.out_crypt   = r.oc;
  assign esp.out_icv_err = r.eicv;
  assign esp.out_pad_err = r.epad;
  assign o_next_hdr      = r.nh;
  assign o_icv_fail      = r.eicv;
  assign o_pad_fail      = r.epad;
endmodule // eptf_dev

/* File: src/eptf_pkg.sv */
package eptf_pkg;
  // widths and sizes
  localparam int unsigned AW        = 11;
  localparam int unsigned MEM_DEPTH = 2048;
  localparam logic [10:0] HDR_LEN   = 11'h008;
  localparam logic [7:0]  ALIGN4    = 8'h03;
  localparam logic [31:0] ICV_SEED  = 32'h5A3C_96E1;

  // controller register offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_SPI   = 8'h04;
  localparam logic [7:0] REG_SEQLO = 8'h08;
  localparam logic [7:0] REG_SEQHI = 8'h0C;
  localparam logic [7:0] REG_PARAM = 8'h10;
  localparam logic [7:0] REG_LEN   = 8'h14;
  localparam logic [7:0] REG_IV0   = 8'h18;
  localparam logic [7:0] REG_IV3   = 8'h24;
  localparam logic [7:0] REG_TXD   = 8'h28;
  localparam logic [7:0] REG_RXD   = 8'h2C;
  localparam logic [7:0] REG_STAT  = 8'h30;

  // control and status bit positions
  localparam int unsigned CTL_GO  = 0;
  localparam int unsigned CTL_DEC = 1;
  localparam int unsigned CTL_CNF = 2;
  localparam int unsigned CTL_INT = 3;
  localparam int unsigned CTL_TFC = 4;
  localparam int unsigned CTL_ESN = 5;
  localparam int unsigned CTL_SA  = 6;
  localparam int unsigned CTL_RP  = 7;
  localparam int unsigned TXD_LST = 8;
  localparam int unsigned ST_REF  = 3;

  // per-association context handed to the framer
  typedef struct packed {
    logic         decrypt;
    logic         conf_en;
    logic         integ_en;
    logic         tfc_en;
    logic         esn_en;
    logic [31:0]  spi;
    logic [31:0]  seq_lo;
    logic [31:0]  seq_hi;
    logic [7:0]   next_hdr;
    logic [4:0]   iv_len;
    logic [7:0]   blk_mask;
    logic [4:0]   icv_len;
    logic [7:0]   tfc_len;
    logic [10:0]  pkt_len;
    logic [127:0] iv;
  } eptf_ctx_t;

  // framer states, one-hot
  typedef enum logic [12:0] {
    S_IDLE = 13'h0001, S_HDR  = 13'h0002, S_IV   = 13'h0004,
    S_BODY = 13'h0008, S_TFC  = 13'h0010, S_PAD  = 13'h0020,
    S_PLEN = 13'h0040, S_NHDR = 13'h0080, S_ICV  = 13'h0100,
    S_DIN  = 13'h0200, S_DLEN = 13'h0400, S_DCHK = 13'h0800,
    S_DOUT = 13'h1000
  } eptf_st_t;
endpackage

/* File: src/eptf_if.sv */
`timescale 1ns/1ps
interface eptf_if;
  import eptf_pkg::*;
  eptf_ctx_t  ctx;
  logic       ctx_load;
  logic       busy;
  logic       in_valid;
  logic [7:0] in_data;
  logic       in_last;
  logic       in_ready;
  logic       out_valid;
  logic [7:0] out_data;
  logic       out_last;
  logic       out_crypt;
  logic       out_icv_err;
  logic       out_pad_err;
  logic       out_ready;

  modport dev (
    input  ctx, ctx_load, in_valid, in_data, in_last, out_ready,
    output busy, in_ready, out_valid, out_data, out_last, out_crypt,
    output out_icv_err, out_pad_err
  );
  modport host (
    output ctx, ctx_load, in_valid, in_data, in_last, out_ready,
    input  busy, in_ready, out_valid, out_data, out_last, out_crypt,
    input  out_icv_err, out_pad_err
  );
endinterface

/* File: src/eptf_host.sv */
`timescale 1ns/1ps
module eptf_host (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // software register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  // link to framer
  eptf_if.host             esp
);
  import eptf_pkg::*;

  typedef struct packed {
    eptf_ctx_t   ctx;
    logic        sa_ok;
    logic        rp_ok;
    logic        load;
    logic        tx_pend;
    logic [7:0]  tx_d;
    logic        tx_l;
    logic        rx_v;
    logic [7:0]  rx_d;
    logic        rx_l;
    logic        rx_c;
    logic        rx_ei;
    logic        rx_ep;
    logic        ordy;
    logic        refused;
    logic [31:0] rdata;
  } eptf_host_t;

  eptf_host_t r;
  eptf_host_t n;
  logic [1:0] ivk;
  logic       in_iv;

  assign ivk   = ~i_addr[3:2] - 2'b10;
  assign in_iv = (i_addr >= REG_IV0) && (i_addr <= REG_IV3);

  ////////////////////////////////////////////////////////////////////////////
  // register access and link staging
  always_comb begin
    n       = r;
    n.load  = 1'b0;
    n.rdata = 32'h0000_0000;
    if (r.tx_pend && esp.in_ready) begin
      n.tx_pend = 1'b0;
    end
    if (i_wr) begin
      case (i_addr)
        REG_CTRL: begin
          n.ctx.decrypt  = i_wdata[CTL_DEC];
          n.ctx.conf_en  = i_wdata[CTL_CNF];
          n.ctx.integ_en = i_wdata[CTL_INT];
          n.ctx.tfc_en   = i_wdata[CTL_TFC];                 // software's call
          n.ctx.esn_en   = i_wdata[CTL_ESN];
          n.sa_ok        = i_wdata[CTL_SA];
          n.rp_ok        = i_wdata[CTL_RP];
          if (i_wdata[CTL_GO]) begin
            // inbound refused unless association and replay checks passed
            if (esp.busy || r.load ||
                (i_wdata[CTL_DEC] && !(i_wdata[CTL_SA] && i_wdata[CTL_RP]))) begin
              n.refused = 1'b1;
            end else begin
              n.load = 1'b1;
            end
          end
        end
        REG_SPI:   n.ctx.spi    = i_wdata;
        REG_SEQLO: n.ctx.seq_lo = i_wdata;
        REG_SEQHI: n.ctx.seq_hi = i_wdata;
        REG_PARAM: begin
          n.ctx.next_hdr = i_wdata[7:0];
          n.ctx.tfc_len  = i_wdata[15:8];
          n.ctx.blk_mask = i_wdata[23:16];
          n.ctx.iv_len   = i_wdata[28:24];
        end
        REG_LEN: begin
          n.ctx.pkt_len = i_wdata[10:0];
          n.ctx.icv_len = i_wdata[20:16];
        end
        REG_TXD: begin
          if (r.tx_pend) begin
            n.refused = 1'b1;                                // one-byte stage full
          end else begin
            n.tx_pend = 1'b1;
            n.tx_d    = i_wdata[7:0];
            n.tx_l    = i_wdata[TXD_LST];
          end
        end
        REG_STAT: if (i_wdata[ST_REF]) n.refused = 1'b0;
        default: if (in_iv) n.ctx.iv[{ivk, 5'h00} +: 32] = i_wdata;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        REG_CTRL: n.rdata = {24'h000000, r.rp_ok, r.sa_ok, r.ctx.esn_en, r.ctx.tfc_en,
                             r.ctx.integ_en, r.ctx.conf_en, r.ctx.decrypt, 1'b0};
        REG_SPI:   n.rdata = r.ctx.spi;
        REG_SEQLO: n.rdata = r.ctx.seq_lo;
        REG_SEQHI: n.rdata = r.ctx.seq_hi;
        REG_PARAM: n.rdata = {3'h0, r.ctx.iv_len, r.ctx.blk_mask, r.ctx.tfc_len,
                              r.ctx.next_hdr};
        REG_LEN:   n.rdata = {11'h000, r.ctx.icv_len, 5'h00, r.ctx.pkt_len};
        REG_RXD: begin
          n.rdata = {20'h00000, r.rx_ep, r.rx_ei, r.rx_c, r.rx_l, r.rx_d};
          n.rx_v  = 1'b0;                                    // read drains the stage
        end
        REG_STAT:  n.rdata = {28'h0000000, r.refused, r.rx_v, r.tx_pend, esp.busy};
        default: if (in_iv) n.rdata = r.ctx.iv[{ivk, 5'h00} +: 32];
      endcase
    end
    // capture after the read so a new byte is never lost
    if (r.ordy && esp.out_valid) begin
      n.rx_v  = 1'b1;
      n.rx_d  = esp.out_data;
      n.rx_l  = esp.out_last;
      n.rx_c  = esp.out_crypt;
      n.rx_ei = esp.out_icv_err;
      n.rx_ep = esp.out_pad_err;
    end
    n.ordy = !n.rx_v;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign o_rdata       = r.rdata;
  assign esp.ctx       = r.ctx;
  assign esp.ctx_load  = r.load;
  assign esp.in_valid  = r.tx_pend;
  assign esp.in_data   = r.tx_d;
  assign esp.in_last   = r.tx_l;
  assign esp.out_ready = r.ordy;
endmodule // eptf_host

/* File: verif/eptf_props.sv */
`timescale 1ns/1ps
module eptf_props (
  // clock and reset
  input wire logic                i_clock,
  input wire logic                i_rst_b,
  // host to framer
  input wire eptf_pkg::eptf_ctx_t ctx,
  input wire logic                ctx_load,
  input wire logic                in_valid,
  input wire logic [7:0]          in_data,
  input wire logic                in_last,
  input wire logic                out_ready,
  // framer to host
  input wire logic                busy,
  input wire logic                in_ready,
  input wire logic                out_valid,
  input wire logic [7:0]          out_data,
  input wire logic                out_last,
  input wire logic                out_crypt,
  input wire logic                out_icv_err,
  input wire logic                out_pad_err
);
  import eptf_pkg::*;
  // one domain, so clock and disable are shared
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // a load only counts while idle
  sequence s_load;
    ctx_load && !busy;
  endsequence
  sequence s_enc_end;
    out_valid && out_last && !ctx.decrypt;
  endsequence

  //////////////////////////////////////////
  // header state needs one cycle before its first byte reaches the slot
  chk_spi_first: assert property (s_load ##0 !ctx.decrypt |=>
    busy ##1 out_valid && out_data == $past(ctx.spi[31:24], 2))
    else $error("first byte is not the spi msb");
  chk_dec_start: assert property (s_load ##0 ctx.decrypt |=> busy && in_ready)
    else $error("decrypt did not open input");
  chk_out_hold: assert property (out_valid && !out_ready |=> out_valid &&
    $stable(out_data) && $stable(out_last) && $stable(out_crypt))
    else $error("output byte changed before taken");
  chk_plain_clear: assert property (out_valid && !ctx.conf_en |-> !out_crypt)
    else $error("crypt mark without confidentiality");
  chk_nh_last: assert property (s_enc_end ##0 !ctx.integ_en |->
    out_data == ctx.next_hdr)
    else $error("last byte is not next header");
  chk_enc_noerr: assert property (s_enc_end |-> !out_icv_err && !out_pad_err)
    else $error("error flag on encrypt");
  // busy drops as the final byte enters the slot, so only that byte may wait
  chk_idle_quiet: assert property (!busy |-> !in_ready && (!out_valid || out_last))
    else $error("traffic while idle");
  chk_busy_end: assert property ($fell(busy) |-> out_valid && out_last && !in_ready)
    else $error("busy fell without final byte");
endmodule // eptf_props

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
  import eptf_pkg::*;
  logic         i_clock = 1'b0;
  logic         i_rst_b = 1'b0;
  logic [7:0]   i_addr  = 8'h00;
  logic [31:0]  i_wdata = 32'h0000_0000;
  logic         i_wr    = 1'b0;
  logic         i_rd    = 1'b0;
  logic [31:0]  o_rdata;
  logic [7:0]   o_next_hdr;
  logic         o_icv_fail;
  logic         o_pad_fail;
  int           num_errors = 0;
  int           n_checks   = 0;
  int           p;
  int           te;
  int           ive;
  logic [31:0]  rv;
  logic [7:0]   pkt[$];
  logic [7:0]   pay[$];
  logic [7:0]   dq[$];
  logic [7:0]   cp[$];
  logic         ecr[$];
  logic [11:0]  got[$];
  logic         conf;
  logic         integ;
  logic         tfc;
  logic         esn;
  logic [7:0]   nh;
  logic [7:0]   tl;
  logic [7:0]   mask;
  logic [4:0]   ivn;
  logic [4:0]   icvn;
  logic [10:0]  plen;
  logic [31:0]  spi;
  logic [31:0]  slo;
  logic [31:0]  shi;
  logic [127:0] iv;

  // both ends face each other, checker watches the link
  eptf_if esp_if ();
  eptf_dev eptf_dev_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .esp(esp_if),
    .o_next_hdr(o_next_hdr), .o_icv_fail(o_icv_fail), .o_pad_fail(o_pad_fail));
  eptf_host eptf_host_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .esp(esp_if));
  eptf_props eptf_props_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .ctx(esp_if.ctx),
    .ctx_load(esp_if.ctx_load), .in_valid(esp_if.in_valid), .in_data(esp_if.in_data),
    .in_last(esp_if.in_last), .out_ready(esp_if.out_ready), .busy(esp_if.busy),
    .in_ready(esp_if.in_ready), .out_valid(esp_if.out_valid),
    .out_data(esp_if.out_data), .out_last(esp_if.out_last),
    .out_crypt(esp_if.out_crypt), .out_icv_err(esp_if.out_icv_err),
    .out_pad_err(esp_if.out_pad_err));

  // 125 MHz
  always #4 i_clock = ~i_clock;

  //////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // strobes last one cycle; a gap cycle keeps one assignment per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  //////////////////////////////////////////
  function automatic logic [31:0] rot(input logic [31:0] s, input logic [7:0] b);
    return {s[30:0], s[31]} ^ {24'h000000, b};
  endfunction

  function automatic void put(input logic [7:0] b, input logic c);
    pkt.push_back(b);
    ecr.push_back(c);
  endfunction

  // reference packet, built byte by byte
  task automatic build();
    logic [31:0] s;
    logic [63:0] hdr;
    pkt = {};
    ecr = {};
    hdr = {spi, slo};
    for (int i = 0; i < 8; i++) put(hdr[63-8*i -: 8], 1'b0);
    for (int i = 0; i < ive; i++) put(iv[127-8*i -: 8], 1'b0);
    foreach (pay[i]) put(pay[i], conf);
    repeat (te) put(8'h00, conf);
    p = (-(pay.size() + te + 2)) & (conf ? int'(mask) : 3);
    for (int k = 1; k <= p; k++) put(8'(k), conf);
    put(8'(p), conf);
    put(nh, conf);
    s = ICV_SEED;
    foreach (pkt[i]) s = rot(s, pkt[i]);
    for (int i = 0; esn && i < 4; i++) s = rot(s, shi[31-8*i -: 8]);
    for (int k = 0; integ && k < icvn; k++) put(8'(s >> (8 * (k % 4))), 1'b0);
  endtask

  // context first, then go; sa and replay bits set before decrypt
  task automatic setup(input logic dec);
    wr(REG_SPI, spi);
    wr(REG_SEQLO, slo);
    wr(REG_SEQHI, shi);
    wr(REG_PARAM, {3'h0, ivn, mask, tl, nh});
    wr(REG_LEN, {11'h000, icvn, 5'h00, plen});
    for (int i = 0; i < 4; i++) wr(REG_IV0 + 8'(4 * i), iv[127-32*i -: 32]);
    wr(REG_CTRL, {24'h000000, 2'b11, esn, tfc, integ, conf, dec, 1'b1});
  endtask

  // host side buffering: feed one byte when free, drain whenever ready
  task automatic xfer(input logic [7:0] src[$]);
    int k;
    k = 0;
    got = {};
    for (int n = 0; n < 3000; n++) begin
      rd(REG_STAT, rv);
      if (rv[2]) begin
        rd(REG_RXD, rv);
        got.push_back(rv[11:0]);
        if (rv[8])
          break;
      end else if (!rv[1] && k < src.size()) begin
        wr(REG_TXD, {23'h000000, k == src.size() - 1, src[k]});
        k++;
      end
    end
    do rd(REG_STAT, rv); while (rv[0]);
  endtask

  //////////////////////////////////////////
  // watchdog well above the expected run
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end

  initial begin
    void'($urandom(86174));
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    rd(REG_STAT, rv);
    chk(rv, 32'h0);
    rd(8'hFC, rv);
    chk(rv, 32'h0);
    wr(REG_CTRL, 32'h0000_0003);
    rd(REG_STAT, rv);
    chk(rv, 32'h0000_0008);
    wr(REG_STAT, 32'h0000_0008);
    rd(REG_STAT, rv);
    chk(rv, 32'h0);
    for (int t = 0; t < 8; t++) begin
      // feature mix drawn at random, tfc included; the first test turns all four on
      {conf, integ, tfc, esn} = (t == 0) ? 4'hF : 4'($urandom);
      {nh, spi, slo, shi, iv} = {8'($urandom), $urandom, $urandom, $urandom,
        $urandom, $urandom, $urandom, $urandom};
      tl   = 8'($urandom % 8);
      ivn  = (t % 2) ? 5'h08 : 5'h10;
      mask = (t % 2) ? 8'h07 : 8'h0F;
      icvn = 5'(12 + 4 * (t % 2));
      te   = tfc ? int'(tl) : 0;
      ive  = conf ? int'(ivn) : 0;
      pay  = {};
      repeat (1 + $urandom % 20) pay.push_back(8'($urandom));
      build();
      plen = 11'(pkt.size());
      setup(1'b0);
      xfer(pay);
      chk(got.size(), pkt.size());
      foreach (pkt[i]) chk(got[i], {2'b00, ecr[i], i == pkt.size() - 1, pkt[i]});
      setup(1'b1);
      xfer(pkt);
      dq = pay;
      repeat (te) dq.push_back(8'h00);
      chk(got.size(), dq.size());
      foreach (dq[i]) chk(got[i], {2'b00, conf, i == dq.size() - 1, dq[i]});
      chk(o_next_hdr, nh);
      if (integ) begin
        cp = pkt;
        cp[8 + ive] = cp[8 + ive] ^ 8'h01;
        setup(1'b1);
        xfer(cp);
        chk(got[$][11:10], 2'b01);
        chk(o_icv_fail, 1'b1);
      end
      if (p > 0) begin
        cp = pkt;
        cp[8 + ive + pay.size() + te] = 8'h40;
        setup(1'b1);
        xfer(cp);
        chk(got[$][11], 1'b1);
        chk(o_pad_fail, 1'b1);
      end
      $display("test %0d done, mismatches %0d", t, num_errors);
    end
    end_sim();
  end
endmodule // tb
